// File: common/lpd_pkg.sv
// Purpose: constants and types for the lcd pin drive control block
// Assumes: byte-wide register port, registers at word offsets of our own choosing
// Notes:   levels are coded as a two-bit selector per pin for the analog pad
package lpd_pkg;
	localparam int          LPD_NPINS       = 22;
	localparam int          LPD_AW          = 4;
	localparam logic [3:0]  LPD_OFS_CTRL    = 4'h0;
	localparam logic [3:0]  LPD_OFS_SEL_LO  = 4'h4;
	localparam logic [3:0]  LPD_OFS_SEL_MID = 4'h8;
	localparam logic [3:0]  LPD_OFS_SEL_HI  = 4'hC;
	localparam int          LPD_BIT_FRAME   = 7;
	localparam int          LPD_BIT_BIAS_HI = 6;
	localparam int          LPD_BIT_BIAS_LO = 5;
	localparam int          LPD_BIT_ON      = 4;
	localparam logic [7:0]  LPD_CTRL_MASK   = 8'hF0;
	localparam logic [7:0]  LPD_SEL_HI_MASK = 8'h3F;
	localparam logic [7:0]  LPD_RST_VAL     = 8'h00;

	// pad level selector
	typedef enum logic [1:0] {
		LPD_LVL_VSS,
		LPD_LVL_VDD,
		LPD_LVL_BIAS_LO,
		LPD_LVL_BIAS_HI
	} lpd_level_t;

	typedef struct packed {
		logic [LPD_AW-1:0] addr;
		logic [7:0]        wdata;
		logic              wr;
		logic              rd;
	} lpd_req_t;

	typedef struct packed {
		logic       frame;
		logic [1:0] bias_strength;
		logic       lcd_master_on;
	} lpd_ctrl_t;
endpackage : lpd_pkg

// File: hw/lpd_pin_level.sv
// Purpose: per-pin level selection from frame, role and data bit
// Assumes: role 0 is common output, 1 is segment output
// Notes:   purely combinational, registered by the caller
`timescale 1ns/100ps
`default_nettype none
module lpd_pin_level
	import lpd_pkg::*;
(
	// control
	input  wire logic       frame,
	input  wire logic       on,
	input  wire logic       role,
	input  wire logic       data,
	// result
	output var lpd_level_t  level
);
	always_comb begin
		if (!on) begin
			level = LPD_LVL_VSS;
		end else if (!role) begin
			// common: frame 0 gives vdd or 1/3, frame 1 gives vss or 2/3
			if (!frame)
				level = data ? LPD_LVL_VDD : LPD_LVL_BIAS_LO;
			else
				level = data ? LPD_LVL_VSS : LPD_LVL_BIAS_HI;
		end else begin
			// segment: frame 0 gives vss or 2/3, frame 1 gives vdd or 1/3
			if (!frame)
				level = data ? LPD_LVL_VSS : LPD_LVL_BIAS_HI;
			else
				level = data ? LPD_LVL_VDD : LPD_LVL_BIAS_LO;
		end
	end
endmodule : lpd_pin_level
`default_nettype wire

// File: hw/lpd_ctrl.sv
// Purpose: register set and pad drive selection for the software lcd driver
// Assumes: plain register port, read data one cycle after read strobe
// Notes:   pad drive ignores port direction; lcd enable and role bits suffice
//
// Operation
// - control bit 7 picks frame phase 0 or 1 for all pins
// - control bits 6..5 choose bias ladder strength, higher code more current
// - control bit 4 turns driver on; off holds every pin at ground
// - control bits 3..0 read zero, ignore writes; 7..4 read/write, reset zero
// - each lcd pin shares a pad with general io, all taken together by control bit 4
// - low select bit n: pin n common at 0, segment at 1
// - mid select bit n: pin 8+n common at 0, segment at 1
// - high select bits 5..0 map pins 21..16; bits 7..6 read zero
// - pin level from frame bit with pin data: supply, ground or bias
// - lcd drive needs no port direction set, enable plus select suffice
//
// Implementation choices: the register addresses and the strobed register port.
`timescale 1ns/100ps
`default_nettype none
module lpd_ctrl
	import lpd_pkg::*;
#(
	parameter int NPINS = LPD_NPINS
)
(
	// clock and reset
	input  wire logic              clock,
	input  wire logic              nrst,
	// register port
	input  wire lpd_req_t          req,
	output logic [7:0]             rdata,
	// shared io data bits
	input  wire logic [NPINS-1:0]  io_data,
	// pad side
	output logic [NPINS-1:0]       lcd_pin_active,
	output var lpd_level_t         pin_level [NPINS],
	output logic [1:0]             bias_strength
);
	lpd_ctrl_t          ctrl_r, ctrl_nxt;
	logic [7:0]         sel_lo_r, sel_lo_nxt;
	logic [7:0]         sel_mid_r, sel_mid_nxt;
	logic [5:0]         sel_hi_r, sel_hi_nxt;
	logic [7:0]         rdata_r, rdata_nxt;
	logic [NPINS-1:0]   role;
	lpd_level_t         level_c [NPINS];
	lpd_level_t         level_r [NPINS];

	function automatic logic [7:0] ctrl_byte(input lpd_ctrl_t c);
		ctrl_byte = {c.frame, c.bias_strength, c.lcd_master_on, 4'h0};
	endfunction : ctrl_byte

	always_comb begin
		ctrl_nxt    = ctrl_r;
		sel_lo_nxt  = sel_lo_r;
		sel_mid_nxt = sel_mid_r;
		sel_hi_nxt  = sel_hi_r;
		rdata_nxt   = 8'h00;
		if (req.wr) begin
			case (req.addr)
				LPD_OFS_CTRL: begin
					ctrl_nxt.frame         = req.wdata[LPD_BIT_FRAME];
					ctrl_nxt.bias_strength = req.wdata[LPD_BIT_BIAS_HI:LPD_BIT_BIAS_LO];
					ctrl_nxt.lcd_master_on = req.wdata[LPD_BIT_ON];
				end
				LPD_OFS_SEL_LO:  sel_lo_nxt  = req.wdata;
				LPD_OFS_SEL_MID: sel_mid_nxt = req.wdata;
				LPD_OFS_SEL_HI:  sel_hi_nxt  = req.wdata[5:0];
				default: ;
			endcase
		end
		if (req.rd) begin
			case (req.addr)
				LPD_OFS_CTRL:    rdata_nxt = ctrl_byte(ctrl_r) & LPD_CTRL_MASK;
				LPD_OFS_SEL_LO:  rdata_nxt = sel_lo_r;
				LPD_OFS_SEL_MID: rdata_nxt = sel_mid_r;
				LPD_OFS_SEL_HI:  rdata_nxt = {2'h0, sel_hi_r} & LPD_SEL_HI_MASK;
				default:         rdata_nxt = 8'h00; // unmapped reads zero
			endcase
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			ctrl_r    <= '0;
			sel_lo_r  <= LPD_RST_VAL;
			sel_mid_r <= LPD_RST_VAL;
			sel_hi_r  <= 6'h00;
			rdata_r   <= 8'h00;
		end else begin
			ctrl_r    <= ctrl_nxt;
			sel_lo_r  <= sel_lo_nxt;
			sel_mid_r <= sel_mid_nxt;
			sel_hi_r  <= sel_hi_nxt;
			rdata_r   <= rdata_nxt;
		end
	end

	assign role = NPINS'({sel_hi_r, sel_mid_r, sel_lo_r});

	// one level selector per pin; io direction deliberately not an input
	for (genvar i = 0; i < NPINS; i++) begin : g_pin
		lpd_pin_level u_lvl (
			.frame (ctrl_r.frame),
			.on    (ctrl_r.lcd_master_on),
			.role  (role[i]),
			.data  (io_data[i]),
			.level (level_c[i])
		);

		always_ff @(posedge clock or negedge nrst) begin
			if (!nrst)
				level_r[i] <= LPD_LVL_VSS;
			else
				level_r[i] <= level_c[i];
		end
	end

	// every pin is handed to the lcd function while enabled; role only picks waveform
	assign lcd_pin_active = {NPINS{ctrl_r.lcd_master_on}};
	assign pin_level      = level_r;
	assign bias_strength  = ctrl_r.bias_strength;
	assign rdata          = rdata_r;
endmodule : lpd_ctrl
`default_nettype wire

// File: dv/lpd_properties.sv
// Purpose: port checks for lpd_ctrl
// Assumes: one clock, async reset
// Notes: frame and roles mirrored from writes, no port shows them
`timescale 1ns/100ps
`default_nettype none
module lpd_props import lpd_pkg::*; #(parameter int NPINS = LPD_NPINS) (
	// bus
	input wire logic clock, nrst,
	input wire lpd_req_t req,
	input wire logic [7:0] rdata,
	// pads
	input wire logic [NPINS-1:0] io_data, lcd_pin_active,
	input var lpd_level_t pin_level [NPINS],
	input wire logic [1:0] bias_strength);
	logic f_r;
	logic [23:0] r_r;
	function automatic lpd_level_t lvl(logic x, logic d);
		return lpd_level_t'(d ? {1'b0, ~x} : {1'b1, x});
	endfunction : lvl
	default clocking cb @(posedge clock); endclocking
	default disable iff (!nrst);
	always_ff @(posedge clock or negedge nrst)
		if (!nrst) {f_r, r_r} <= '0;
		else if (req.wr) case (req.addr)
			4'h0: f_r <= req.wdata[7];
			4'h4: r_r[7:0] <= req.wdata;
			4'h8: r_r[15:8] <= req.wdata;
			4'hC: r_r[23:16] <= req.wdata & 8'h3F;
			default: ;
		endcase
	a_ctrl_rd: assert property (req.rd && req.addr == 4'h0 |=>
		rdata == {$past({f_r, bias_strength, lcd_pin_active[0]}), 4'h0}) else $error("ctrl read");
	a_lo_rd: assert property (req.rd && req.addr == 4'h4 |=> rdata == $past(r_r[7:0])) else $error("lo read");
	a_mid_rd: assert property (req.rd && req.addr == 4'h8 |=> rdata == $past(r_r[15:8])) else $error("mid read");
	a_hi_rd: assert property (req.rd && req.addr == 4'hC |=> rdata == $past(r_r[23:16])) else $error("hi read");
	a_ctrl_wr: assert property (req.wr && req.addr == 4'h0 |=>
		bias_strength == $past(req.wdata[6:5]) && lcd_pin_active == {NPINS{$past(req.wdata[4])}}) else $error("ctrl write");
	a_bias_hold: assert property (!(req.wr && req.addr == 4'h0) |=> $stable(bias_strength)) else $error("bias moved");
	for (genvar i = 0; i < NPINS; i++) begin : g_pin
		a_off_gnd: assert property (!lcd_pin_active[i] |=> pin_level[i] == LPD_LVL_VSS) else $error("not ground");
		a_pin_lvl: assert property (lcd_pin_active[i] |=>
			pin_level[i] == lvl($past(f_r ^ r_r[i]), $past(io_data[i]))) else $error("pin level");
	end
	c_on: cover property (req.wr && req.addr == 4'h0 && req.wdata[4]);
	c_hi: cover property (req.rd && req.addr == 4'hC);
	c_frame: cover property (lcd_pin_active[0] && f_r);
endmodule : lpd_props
bind lpd_ctrl lpd_props #(.NPINS(NPINS)) u_props (.clock(clock), .nrst(nrst), .req(req), .rdata(rdata),
	.io_data(io_data), .lcd_pin_active(lcd_pin_active), .pin_level(pin_level), .bias_strength(bias_strength));
`default_nettype wire

// File: dv/lpd_panel.sv
// Purpose: lcd glass stand-in on the shared pads
// Assumes: pads read only once settled
// Notes: flags any pad off ground while released
`timescale 1ns/100ps
`default_nettype none
module lpd_panel import lpd_pkg::*; (
	// pads in, glass state out
	input wire logic [LPD_NPINS-1:0] lcd_pin_active,
	input var lpd_level_t pin_level [LPD_NPINS],
	output logic fault);
	// dc across the glass while off ages it, so any level but ground counts
	always_comb begin
		fault = 1'b0;
		for (int i = 0; i < LPD_NPINS; i++) fault |= !lcd_pin_active[i] && pin_level[i] != LPD_LVL_VSS;
	end
endmodule : lpd_panel
`default_nettype wire

// File: dv/lpd_ctrl_tb.sv
// Purpose: random register and pad tests
// Assumes: read data in the cycle after the strobe
// Notes: levels from the bench's own model
`timescale 1ns/100ps
`default_nettype none
module lpd_ctrl_tb import lpd_pkg::*; ;
	logic clock, nrst, fault;
	lpd_req_t req;
	logic [7:0] rdata, c;
	logic [23:0] s;
	logic [21:0] io_data, lcd_pin_active;
	lpd_level_t pin_level [22];
	logic [1:0] bias_strength;
	int error_cnt = 0, cmp_count = 0, seed = 40;
	lpd_ctrl u_lpd_ctrl (.clock(clock), .nrst(nrst), .req(req), .rdata(rdata), .io_data(io_data),
		.lcd_pin_active(lcd_pin_active), .pin_level(pin_level), .bias_strength(bias_strength));
	lpd_panel u_lpd_panel (.lcd_pin_active(lcd_pin_active), .pin_level(pin_level), .fault(fault));
	initial begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end
	function automatic logic [1:0] lvl(logic x, logic d);
		return x ? (d ? 2'h0 : 2'h3) : (d ? 2'h1 : 2'h2);
	endfunction : lvl
	task automatic chk(string n, logic [21:0] e, logic [21:0] v);
		cmp_count++;
		if (v !== e) error_cnt++;
		if (v !== e) $display("Error %s expected %h seen %h", n, e, v);
	endtask : chk
	task automatic wr(logic [3:0] a, logic [7:0] d);
		@(posedge clock) req <= '{a, d, 1'b1, 1'b0};
	endtask : wr
	task automatic rd(logic [3:0] a, logic [7:0] e);
		@(posedge clock) req <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge clock) req.rd <= 1'b0;
		@(negedge clock) chk("rdata", 22'(e), 22'(rdata));
	endtask : rd
	task automatic complete_run;
		$display("compares %0d errors %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : complete_run
	initial begin
		#100000;
		error_cnt++;
		complete_run();
	end
	initial begin
		{nrst, req, io_data} = '0;
		repeat (8) @(posedge clock);
		nrst <= 1'b1;
		for (int i = 0; i < 4; i++) rd(4'(4 * i), 8'h00);
		wr(4'h2, 8'hFF);
		rd(4'h2, 8'h00);
		rd(LPD_OFS_CTRL, 8'h00);
		for (int i = 0; i < 8; i++) begin
			c = 8'($random(seed));
			s = 24'($random(seed));
			c[6:5] = 2'(i);
			c[7] = i[0];
			if (i == 0) c[4] = 1'b0;
			if (i == 7) s = '1;
			wr(LPD_OFS_CTRL, c);
			wr(LPD_OFS_SEL_LO, s[7:0]);
			wr(LPD_OFS_SEL_MID, s[15:8]);
			wr(LPD_OFS_SEL_HI, s[23:16]);
			rd(LPD_OFS_CTRL, c & LPD_CTRL_MASK);
			rd(LPD_OFS_SEL_LO, s[7:0]);
			rd(LPD_OFS_SEL_MID, s[15:8]);
			rd(LPD_OFS_SEL_HI, s[23:16] & LPD_SEL_HI_MASK);
			@(posedge clock) io_data <= 22'($random(seed));
			repeat (2) @(posedge clock);
			@(negedge clock) chk("active", {22{c[4]}}, lcd_pin_active);
			chk("bias", 22'(c[6:5]), 22'(bias_strength));
			chk("panel", 22'h0, 22'(fault));
			for (int p = 0; p < 22; p++) chk("level", c[4] ? 22'(lvl(c[7] ^ s[p], io_data[p])) : 22'h0, 22'(pin_level[p]));
			$display("test %0d done", i);
		end
		complete_run();
	end
endmodule : lpd_ctrl_tb
`default_nettype wire
